// *** inc/adcc_pkg.sv ***
// Purpose: constants and types for the converter control block
// Assumes: registers are 8 bits wide, one per aligned 32-bit word
// Notes: analog core sits outside; this block only steers and sequences it
// How it works
// - internal source disconnects all external channels
// - format bit arranges result across two bytes
// - reference select; amp settings only when chosen
// - interrupt needs global and conversion enable
// - start bit low-high-low begins conversion
// - busy high during conversion, result then readable
// - power enable low switches converter off
// - results twelve bits, full scale all ones
// - one step is reference over 4096
// - control1 value 03h: divide by eight, external
// - control0 value 20h: power on, channel zero
// - control2 value 00h: supply as reference
// - four sample plus twelve convert clocks
// - divider field selects divide by 1..128
// - source codes 1..3, 5..7 and 8..11 are internal
// - end of conversion sets request flag always
package adcc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_CTRL2 = 8'h08;
    localparam logic [7:0] OFF_RES_HI = 8'h0c;
    localparam logic [7:0] OFF_RES_LO = 8'h10;
    localparam logic [7:0] OFF_IRQ_CTRL = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    // field positions
    localparam int CTRL0_CH_LSB = 0;
    localparam int CTRL0_FMT = 4;
    localparam int CTRL0_PWR = 5;
    localparam int CTRL0_BUSY = 6;
    localparam int CTRL0_START = 7;
    localparam int CTRL1_DIV_LSB = 0;
    localparam int CTRL1_SRC_LSB = 4;
    localparam int CTRL2_REF_LSB = 0;
    localparam int CTRL2_AMPIN_LSB = 4;
    localparam int CTRL2_GAIN_LSB = 6;
    localparam int IRQ_CONV_EN = 0;
    localparam int IRQ_GLOBAL_EN = 1;
    localparam int STAT_CONV_FLAG = 0;
    // reset values
    localparam logic [7:0] RST_CTRL0 = 8'h00;
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [7:0] RST_IRQ = 8'h00;
    // reference code that picks the amplifier output
    localparam logic [1:0] REF_AMP = 2'h1;
    // conversion phase lengths in conversion clocks
    localparam logic [3:0] SAMPLE_TICKS = 4'h4;
    localparam logic [4:0] TOTAL_TICKS = 5'h10;
    localparam int RES_BITS = 12;
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ADCC_IDLE = 3'b001,
        ADCC_SAMPLE = 3'b010,
        ADCC_CONVERT = 3'b100
    } adcc_state_t;
    // steering towards the analog core
    typedef struct packed {
        logic power_on;
        logic ext_connect;
        logic [3:0] ext_channel_sel;
        logic [3:0] input_source_sel;
        logic [1:0] ref_source_sel;
        logic [1:0] amp_input_sel;
        logic [1:0] amp_gain_sel;
        logic sample;
        logic conv_clk_tick;
    } adcc_analog_t;
endpackage : adcc_pkg

// *** logic/adcc_top.sv ***
// Purpose: register file and sequencer for the successive-conversion ADC
// Assumes: AXI4-Lite slave, 8-bit registers in the low byte lane
// Notes: analog result arrives from the core and is synchronised here
`timescale 1ns/1ps
module adcc_top import adcc_pkg::*; #(
    parameter int DIV_BITS = 7
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog core
    input wire logic [RES_BITS-1:0] core_code,
    output adcc_analog_t analog,
    // interrupt
    output logic irq
);
    // software registers
    logic [7:0] ctrl0; // channel, format, power, start
    logic [7:0] ctrl1; // divider, input source
    logic [7:0] ctrl2; // reference and amplifier
    logic [7:0] irq_ctrl; // enables
    logic conv_flag; // sticky end-of-conversion
    logic [7:0] res_hi; // result high byte
    logic [7:0] res_lo; // result low byte
    logic busy; // conversion running
    // bus bookkeeping
    logic aw_held, w_held;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_lane0;
    logic do_wr;
    logic wr_hit;
    logic [7:0] rd_val;
    logic rd_hit;
    // sequencer
    adcc_state_t state;
    logic [DIV_BITS-1:0] div_cnt;
    logic [DIV_BITS-1:0] div_last;
    logic tick;
    logic [4:0] tick_cnt;
    logic start_q; // start bit one cycle ago
    logic start_go, start_rise;
    logic finish;
    logic [RES_BITS-1:0] code_s1, code_s2;
    logic internal_src;

    // write channels taken independently, held until both are present
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_wr = aw_held && w_held && !s_axi_bvalid;

    // capture write address
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held <= 1'b0;
            wr_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_held <= 1'b0;
        end
    end

    // capture write data; only the low lane carries register bits
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            w_held <= 1'b0;
            wr_data <= 8'h00;
            wr_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
        end else if (do_wr) begin
            w_held <= 1'b0;
        end
    end

    // decode of the write target
    always_comb begin
        case (wr_addr)
            OFF_CTRL0, OFF_CTRL1, OFF_CTRL2,
            OFF_RES_HI, OFF_RES_LO,
            OFF_IRQ_CTRL, OFF_IRQ_STAT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // write response, slverr for unmapped offsets
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control registers; result bytes are read-only and ignore writes
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl0 <= RST_CTRL0;
            ctrl1 <= RST_CTRL1;
            ctrl2 <= RST_CTRL2;
            irq_ctrl <= RST_IRQ;
        end else if (do_wr && wr_lane0) begin
            case (wr_addr)
                OFF_CTRL0: ctrl0 <= wr_data;
                OFF_CTRL1: ctrl1 <= wr_data;
                OFF_CTRL2: ctrl2 <= wr_data;
                OFF_IRQ_CTRL: irq_ctrl <= wr_data;
                default: ;
            endcase
        end
    end

    // read data mux; busy is live state, upper bits read zero
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFF_CTRL0: rd_val = {ctrl0[7], busy, ctrl0[5:0]};
            OFF_CTRL1: rd_val = ctrl1;
            OFF_CTRL2: rd_val = ctrl2;
            OFF_RES_HI: rd_val = res_hi;
            OFF_RES_LO: rd_val = res_lo;
            OFF_IRQ_CTRL: rd_val = irq_ctrl;
            OFF_IRQ_STAT: rd_val = {7'h00, conv_flag};
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // read channel: one read in flight, answered the next cycle
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_val};
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // start bit history for the low-high-low pulse
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= ctrl0[CTRL0_START];
        end
    end
    // rising edge resets the converter, falling edge launches it
    assign start_rise = ctrl0[CTRL0_START] && !start_q;
    assign start_go = !ctrl0[CTRL0_START] && start_q;

    // prescaler: terminal count is 2^div - 1, so code 000 ticks every clock
    assign div_last = DIV_BITS'((1 << ctrl1[CTRL1_DIV_LSB +: 3]) - 1);
    assign tick = (div_cnt == div_last);
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= '0;
        end else if (state == ADCC_IDLE || tick) begin
            div_cnt <= '0; // phase aligned to the start of each conversion
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // last conversion clock of the sixteen
    assign finish = (state == ADCC_CONVERT) && tick &&
                    (tick_cnt == TOTAL_TICKS - 5'h01);

    // sequencer: sample for four ticks, convert for twelve
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ADCC_IDLE;
            tick_cnt <= 5'h00;
        end else if (!ctrl0[CTRL0_PWR] || start_rise) begin
            state <= ADCC_IDLE;
            tick_cnt <= 5'h00;
        end else begin
            case (state)
                ADCC_IDLE: begin
                    tick_cnt <= 5'h00;
                    if (start_go) begin
                        state <= ADCC_SAMPLE;
                    end
                end
                ADCC_SAMPLE: begin
                    if (tick) begin
                        tick_cnt <= tick_cnt + 5'h01;
                        if (tick_cnt == {1'b0, SAMPLE_TICKS} - 5'h01) begin
                            state <= ADCC_CONVERT;
                        end
                    end
                end
                ADCC_CONVERT: begin
                    if (finish) begin
                        state <= ADCC_IDLE;
                        tick_cnt <= 5'h00;
                    end else if (tick) begin
                        tick_cnt <= tick_cnt + 5'h01;
                    end
                end
                default: begin
                    state <= ADCC_IDLE;
                    tick_cnt <= 5'h00;
                end
            endcase
        end
    end
    assign busy = (state != ADCC_IDLE);

    // code from the analog core passes two flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            code_s1 <= '0;
            code_s2 <= '0;
        end else begin
            code_s1 <= core_code;
            code_s2 <= code_s1;
        end
    end

    // result bytes only change when a conversion completes
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            res_hi <= 8'h00;
            res_lo <= 8'h00;
        end else if (finish) begin
            if (ctrl0[CTRL0_FMT]) begin
                res_hi <= {4'h0, code_s2[11:8]};
                res_lo <= code_s2[7:0];
            end else begin
                res_hi <= code_s2[11:4];
                res_lo <= {code_s2[3:0], 4'h0};
            end
        end
    end

    // sticky flag: set wins over a write-one clear in the same cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            conv_flag <= 1'b0;
        end else if (finish) begin
            conv_flag <= 1'b1;
        end else if (do_wr && wr_lane0 && wr_addr == OFF_IRQ_STAT &&
                     wr_data[STAT_CONV_FLAG]) begin
            conv_flag <= 1'b0;
        end
    end

    // level interrupt gated by both enables
    assign irq = conv_flag && irq_ctrl[IRQ_CONV_EN] &&
                 irq_ctrl[IRQ_GLOBAL_EN];

    // source codes 0001..0011 and 0101..0111, 10xx are internal
    assign internal_src = (ctrl1[CTRL1_SRC_LSB+2 +: 2] == 2'b10) ||
                          (!ctrl1[CTRL1_SRC_LSB+3]
                           && ctrl1[CTRL1_SRC_LSB +: 2] != 2'b00);

    // analog steering; a step is reference/4096 in the core itself
    always_comb begin
        analog.power_on = ctrl0[CTRL0_PWR];
        analog.ext_connect = ctrl0[CTRL0_PWR] && !internal_src;
        analog.ext_channel_sel = ctrl0[CTRL0_CH_LSB +: 4];
        analog.input_source_sel = ctrl1[CTRL1_SRC_LSB +: 4];
        analog.ref_source_sel = ctrl2[CTRL2_REF_LSB +: 2];
        // amplifier settings take effect only when it is the reference
        if (ctrl2[CTRL2_REF_LSB +: 2] == REF_AMP) begin
            analog.amp_input_sel = ctrl2[CTRL2_AMPIN_LSB +: 2];
            analog.amp_gain_sel = ctrl2[CTRL2_GAIN_LSB +: 2];
        end else begin
            analog.amp_input_sel = 2'h0;
            analog.amp_gain_sel = 2'h0;
        end
        analog.sample = (state == ADCC_SAMPLE);
        analog.conv_clk_tick = busy && tick;
    end
endmodule : adcc_top

// *** verification/adcc_asserts.sv ***
// Purpose: port-level checks for the converter control block
// Assumes: bound to every adcc_top instance
// Notes: busy is only visible by register read, so the bench times it
`timescale 1ns/1ps
module adcc_asserts import adcc_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // analog steering
    input wire adcc_analog_t analog
);
    logic [2:0] samp_ticks; // ticks seen in one sample phase
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // counts ticks while sampling; a counter avoids a long repetition
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            samp_ticks <= 3'h0;
        else if (!analog.sample)
            samp_ticks <= 3'h0;
        else if (analog.conv_clk_tick)
            samp_ticks <= samp_ticks + 3'h1;
    end
    // both write channels taken at one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_ext_cut: assert property (
        analog.input_source_sel inside {[4'h1:4'h3], [4'h5:4'hb]}
        |-> !analog.ext_connect) else $error("external input connected");
    a_amp_gate: assert property (
        analog.ref_source_sel != REF_AMP |-> analog.amp_input_sel == 2'h0
        && analog.amp_gain_sel == 2'h0) else $error("amp fields leak");
    a_samp_len: assert property (samp_ticks <= 3'h4)
        else $error("sample phase too long");
    a_pwr_idle: assert property (
        !analog.power_on [*2] |-> !analog.sample && !analog.conv_clk_tick)
        else $error("sequencer runs while powered off");
    a_wr_resp: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_rd_resp: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read response late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp drop");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata drop");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
        |-> s_axi_rdata == 32'h0) else $error("error read not zero");
endmodule : adcc_asserts
bind adcc_top adcc_asserts u_chk (.mclk, .arst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .analog);

// *** verification/adcc_top_test.sv ***
// Purpose: self-checking bench for the converter control block
// Assumes: bus master waits for every answer, watchdog cuts hangs
// Notes: the model works out results, timing and irq from plain ints
`timescale 1ns/1ps
module adcc_top_test;
    import adcc_pkg::*;
    logic mclk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] core_code;
    adcc_analog_t analog;
    int mismatches, samples_checked, seed, samp_cyc, ticks, v, hi;
    adcc_top uut (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_code, .analog,
        .irq);
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // conversion timing seen at the steering port
    always @(posedge mclk) begin
        samp_cyc += int'(analog.sample === 1'b1);
        ticks += int'(analog.conv_clk_tick === 1'b1);
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one write; both channels offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, d, input logic [3:0] st = 4'h1,
            input logic [1:0] er = 2'h0);
        bit aw_ok, w_ok;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'($random(seed)), d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge mclk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] er = 2'h0, input bit cmp = 1);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (cmp) begin
            chk("rdata", e, rd);
            chk("rresp", 32'(er), 32'(s_axi_rresp));
        end
    endtask : rd_chk
    // full conversion polled on busy, then both result bytes
    task automatic conv(input logic [2:0] dv, input bit fm, input int c);
        c = c & 'hfff; // the core only delivers twelve bits
        core_code <= 12'(c);
        wr(OFF_CTRL1, {5'h0, dv});
        wr(OFF_CTRL0, {3'h5, fm, 4'h0});
        samp_cyc = 0;
        ticks = 0;
        wr(OFF_CTRL0, {3'h1, fm, 4'h0});
        do rd_chk(OFF_CTRL0, 0, 0, 0); while (rd[6] === 1'b1);
        chk("sample cycles", 4 << dv, samp_cyc);
        chk("ticks", 16, ticks);
        hi = fm ? c >> 8 : c >> 4;
        rd_chk(OFF_RES_LO, fm ? c & 'hff : (c & 'hf) << 4);
        core_code <= ~12'(c);
        rd_chk(OFF_RES_HI, hi);
    endtask : conv
    task automatic end_of_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        end_of_test();
    end
    initial begin
        seed = 32'h12c9;
        {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
        {s_axi_wdata, s_axi_wstrb, core_code} = 0;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd_chk(8'(4 * i), 0);
        end
        wr(OFF_CTRL2, 8'h00);
        chk("ref", 0, analog.ref_source_sel);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed) & 'hf0 | i;
            wr(OFF_CTRL2, 8'(v));
            chk("ref path", i == 1 ? v : i, {analog.amp_gain_sel,
                analog.amp_input_sel, 2'h0, analog.ref_source_sel});
        end
        wr(OFF_CTRL1, 8'h03);
        wr(OFF_CTRL0, 8'h20);
        chk("steer", 'h300, {analog.power_on, analog.ext_connect,
            analog.ext_channel_sel, analog.input_source_sel});
        for (int s = 0; s < 16; s++) begin
            wr(OFF_CTRL1, {4'(s), 4'h3});
            chk("connect", s == 0 || s == 4 || s > 11,
                analog.ext_connect);
        end
        for (int i = 0; i < 4; i++) begin
            conv(3'(i * 3 % 4), i % 2, i == 3 ? 'hfff : $random(seed));
        end
        rd_chk(OFF_IRQ_STAT, 1);
        for (int m = 0; m < 4; m++) begin
            wr(OFF_IRQ_CTRL, 8'(m));
            chk("irq", m == 3, irq);
        end
        wr(OFF_IRQ_STAT, 8'h01);
        chk("irq", 0, irq);
        conv(3'h2, 1'b0, $random(seed));
        chk("irq", 1, irq);
        wr(OFF_IRQ_STAT, 8'h01);
        wr(OFF_RES_HI, 8'hff);
        rd_chk(OFF_RES_HI, hi);
        wr(OFF_CTRL2, 8'h55, 4'h0);
        rd_chk(OFF_CTRL2, v);
        wr(8'h1c, 8'h11, 4'h1, 2'h2);
        rd_chk(8'h1c, 0, 2'h2);
        wr(OFF_CTRL0, 8'h00);
        chk("power", 0, analog.power_on);
        samp_cyc = 0;
        wr(OFF_CTRL0, 8'h80);
        wr(OFF_CTRL0, 8'h00);
        rd_chk(OFF_IRQ_STAT, 0);
        chk("sample cycles", 0, samp_cyc);
        end_of_test();
    end
endmodule : adcc_top_test
